// ---- design/operand_address_generator_regs.vh ----
`ifndef OPERAND_ADDRESS_GENERATOR_REGS_VH
`define OPERAND_ADDRESS_GENERATOR_REGS_VH

// Addressing modes on addr_mode
`define MODE_IMPLIED 4'h0
`define MODE_BYTE_REG 4'h1
`define MODE_PAIR_REG 4'h2
`define MODE_DIRECT 4'h3
`define MODE_SHORT_DIRECT 4'h4
`define MODE_SPECIAL_REG 4'h5
`define MODE_REG_INDIRECT 4'h6
`define MODE_BASED 4'h7
`define MODE_BASED_INDEXED 4'h8
`define MODE_STACK 4'h9

// Implied-operand instruction classes on implied_op
`define UNSIGNED_MULTIPLY_OP 3'h0
`define UNSIGNED_WORD_DIVIDE_OP 3'h1
`define DECIMAL_ADJUST_AFTER_ADD 3'h2
`define DECIMAL_ADJUST_AFTER_SUB 3'h3
`define DIGIT_ROTATE_LEFT 3'h4
`define DIGIT_ROTATE_RIGHT 3'h5

// Byte register codes
`define CODE_X 3'h0
`define CODE_A 3'h1
`define CODE_C 3'h2
`define CODE_B 3'h3
`define CODE_E 3'h4
`define CODE_D 3'h5
`define CODE_L 3'h6
`define CODE_H 3'h7

// Pair register codes
`define PAIR_AX 2'h0
`define PAIR_BC 2'h1
`define PAIR_DE 2'h2
`define PAIR_HL 2'h3

// Short direct window FE20H..FF1FH
`define SHORT_HIGH_BITS 7'h7F
`define SHORT_SPLIT 8'h20
`define SHORT_RAM_PAGE 1'h0
`define SHORT_SFR_PAGE 1'h1

// Special register space, with the FFD0H..FFDFH hole unreachable
`define SPECIAL_HIGH_BYTE 8'hFF
`define SPECIAL_HOLE_LO 8'hD0
`define SPECIAL_HOLE_HI 8'hDF

// Internal high-speed RAM bounds for stack accesses
`define STACK_RAM_LO 16'hFB00
`define STACK_RAM_HI 16'hFEFF

`define ZERO_BYTE 8'h00
`define ZERO_WORD 16'h0000
`define ZERO_SLOT 5'h00
`define REG_COUNT 32

`endif

// ---- design/operand_address_generator.v ----
// How it works
// - Multiply reads A and X implicitly, writes the whole product into AX.
// - Decimal adjust after add or subtract operates on A, no operand field.
// - Digit rotate left and right keep their digit data in A.
// - Register operand chosen by two bank bits plus 3-bit register code.
// - Byte codes 0..7 are X,A,C,B,E,D,L,H; pair codes 0..3 AX,BC,DE,HL.
// - Direct mode passes the 16-bit immediate through as the address.
// - Short direct reaches only the 256-byte window FE20H to FF1FH.
// - Window lower part FE20H-FEFFH is RAM, upper FF00H-FF1FH special registers.
// - Short immediate 20H..FFH gives address bit 8 equal zero.
// - Short immediate 00H..1FH gives address bit 8 equal one.
// - Special register mode reaches FF00H-FFCFH and FFE0H-FFFFH only.
// - Register indirect uses DE or HL of current bank as full address.
// - Based mode adds zero-extended immediate to HL, carry dropped.
// - Based indexed adds zero-extended B or C to HL, carry dropped.
// - Push, pop, call, return and interrupt save address via stack pointer.
// - Stack accesses outside internal high-speed RAM are refused.
`timescale 1ns/100ps
`include "operand_address_generator_regs.vh"

module operand_address_generator (
  input wire sys_clk,
  input wire reset_n,
  input wire clk_en,
  input wire req_valid,
  input wire [3:0] addr_mode,
  input wire [2:0] implied_op,
  input wire [2:0] byte_register_code,
  input wire [1:0] pair_register_code,
  input wire index_use_c,
  input wire bank_select_bit0,
  input wire bank_select_bit1,
  input wire [7:0] imm8,
  input wire [15:0] imm16,
  input wire word_access,
  input wire [15:0] stack_pointer,
  input wire wr_en,
  input wire [2:0] wr_byte_code,
  input wire [7:0] wr_data,
  output wire done,
  output wire [15:0] eff_addr,
  output wire [15:0] eff_addr_upper,
  output wire mem_access,
  output wire reg_access,
  output wire [4:0] reg_slot,
  output wire [15:0] operand_data,
  output wire addr_fault,
  output wire product_written
);

  reg [7:0] gpr [0:`REG_COUNT-1];
  reg done_reg;
  reg [15:0] eff_addr_reg;
  reg [15:0] eff_addr_upper_reg;
  reg mem_access_reg;
  reg reg_access_reg;
  reg [4:0] reg_slot_reg;
  reg [15:0] operand_data_reg;
  reg addr_fault_reg;
  reg product_written_reg;

  reg [15:0] eff_addr_next;
  reg mem_access_next;
  reg reg_access_next;
  reg [4:0] reg_slot_next;
  reg [15:0] operand_data_next;
  reg addr_fault_next;
  reg product_next;

  wire [1:0] bank;
  wire [7:0] bank_x;
  wire [7:0] bank_a;
  wire [7:0] bank_c;
  wire [7:0] bank_b;
  wire [7:0] bank_e;
  wire [7:0] bank_d;
  wire [7:0] bank_l;
  wire [7:0] bank_h;
  wire [63:0] bank_regs;
  wire [15:0] hl_word;
  wire [15:0] ax_product;
  wire [7:0] index_byte;
  integer i;

  function [4:0] slot_of;
    input [1:0] bank_sel;
    input [2:0] code;
    begin
      slot_of = {bank_sel, code};
    end
  endfunction

  // Pair p sits on byte codes 2p (low) and 2p+1 (high), as AX = A:X
  function [15:0] pair_word;
    input [63:0] regs;
    input [1:0] pcode;
    begin
      pair_word = regs[{pcode, 4'h0} +: 16];
    end
  endfunction

  function [7:0] byte_of;
    input [63:0] regs;
    input [2:0] code;
    begin
      byte_of = regs[{code, 3'h0} +: 8];
    end
  endfunction

  assign bank = {bank_select_bit1, bank_select_bit0};
  // Bank passed to functions by value; a function reading the array
  // itself would leave the decode blind to register writes
  assign bank_x = gpr[{bank, `CODE_X}];
  assign bank_a = gpr[{bank, `CODE_A}];
  assign bank_c = gpr[{bank, `CODE_C}];
  assign bank_b = gpr[{bank, `CODE_B}];
  assign bank_e = gpr[{bank, `CODE_E}];
  assign bank_d = gpr[{bank, `CODE_D}];
  assign bank_l = gpr[{bank, `CODE_L}];
  assign bank_h = gpr[{bank, `CODE_H}];
  assign bank_regs = {bank_h, bank_l, bank_d, bank_e, bank_b, bank_c, bank_a, bank_x};
  assign hl_word = pair_word(bank_regs, `PAIR_HL);
  assign ax_product = {`ZERO_BYTE, bank_a} * {`ZERO_BYTE, bank_x};
  assign index_byte = index_use_c ? bank_c : bank_b;

  always @* begin
    eff_addr_next = `ZERO_WORD;
    mem_access_next = 1'b0;
    reg_access_next = 1'b0;
    reg_slot_next = `ZERO_SLOT;
    operand_data_next = `ZERO_WORD;
    addr_fault_next = 1'b0;
    product_next = 1'b0;
    case (addr_mode)
      `MODE_IMPLIED: begin
        reg_access_next = 1'b1;
        case (implied_op)
          `UNSIGNED_MULTIPLY_OP: begin
            reg_slot_next = slot_of(bank, `CODE_A);
            operand_data_next = ax_product;
            product_next = 1'b1;
          end
          `UNSIGNED_WORD_DIVIDE_OP: begin
            // Dividend and quotient live in X
            reg_slot_next = slot_of(bank, `CODE_X);
            operand_data_next = {`ZERO_BYTE, bank_x};
          end
          `DECIMAL_ADJUST_AFTER_ADD, `DECIMAL_ADJUST_AFTER_SUB: begin
            reg_slot_next = slot_of(bank, `CODE_A);
            operand_data_next = {`ZERO_BYTE, bank_a};
          end
          `DIGIT_ROTATE_LEFT, `DIGIT_ROTATE_RIGHT: begin
            reg_slot_next = slot_of(bank, `CODE_A);
            operand_data_next = {`ZERO_BYTE, bank_a};
          end
          default: begin
            reg_access_next = 1'b0;
            addr_fault_next = 1'b1;
          end
        endcase
      end
      `MODE_BYTE_REG: begin
        reg_access_next = 1'b1;
        reg_slot_next = slot_of(bank, byte_register_code);
        operand_data_next = {`ZERO_BYTE, byte_of(bank_regs, byte_register_code)};
      end
      `MODE_PAIR_REG: begin
        reg_access_next = 1'b1;
        reg_slot_next = slot_of(bank, {pair_register_code, 1'b0});
        operand_data_next = pair_word(bank_regs, pair_register_code);
      end
      `MODE_DIRECT: begin
        mem_access_next = 1'b1;
        eff_addr_next = imm16;
      end
      `MODE_SHORT_DIRECT: begin
        mem_access_next = 1'b1;
        // Bit 8 folds 00H..1FH onto FF00H so the window stays contiguous
        if (imm8 < `SHORT_SPLIT) begin
          eff_addr_next = {`SHORT_HIGH_BITS, `SHORT_SFR_PAGE, imm8};
        end else begin
          eff_addr_next = {`SHORT_HIGH_BITS, `SHORT_RAM_PAGE, imm8};
        end
      end
      `MODE_SPECIAL_REG: begin
        if (imm8 >= `SPECIAL_HOLE_LO && imm8 <= `SPECIAL_HOLE_HI) begin
          addr_fault_next = 1'b1;
        end else begin
          mem_access_next = 1'b1;
          eff_addr_next = {`SPECIAL_HIGH_BYTE, imm8};
        end
      end
      `MODE_REG_INDIRECT: begin
        if (pair_register_code == `PAIR_DE || pair_register_code == `PAIR_HL) begin
          mem_access_next = 1'b1;
          eff_addr_next = pair_word(bank_regs, pair_register_code);
        end else begin
          addr_fault_next = 1'b1;
        end
      end
      `MODE_BASED: begin
        mem_access_next = 1'b1;
        eff_addr_next = hl_word + {`ZERO_BYTE, imm8};
      end
      `MODE_BASED_INDEXED: begin
        mem_access_next = 1'b1;
        eff_addr_next = hl_word + {`ZERO_BYTE, index_byte};
      end
      `MODE_STACK: begin
        // Caller presents the pointer already stepped for push or pop
        if (stack_pointer >= `STACK_RAM_LO && stack_pointer <= `STACK_RAM_HI) begin
          mem_access_next = 1'b1;
          eff_addr_next = stack_pointer;
        end else begin
          addr_fault_next = 1'b1;
        end
      end
      default: begin
        addr_fault_next = 1'b1;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      done_reg <= 1'b0;
      eff_addr_reg <= `ZERO_WORD;
      eff_addr_upper_reg <= `ZERO_WORD;
      mem_access_reg <= 1'b0;
      reg_access_reg <= 1'b0;
      reg_slot_reg <= `ZERO_SLOT;
      operand_data_reg <= `ZERO_WORD;
      addr_fault_reg <= 1'b0;
      product_written_reg <= 1'b0;
    end else if (clk_en) begin
      done_reg <= req_valid;
      product_written_reg <= req_valid && product_next;
      if (req_valid) begin
        eff_addr_reg <= eff_addr_next;
        // Word partner is addr|1; an odd base from software would alias
        // Only memory results get a partner; faults and registers keep zero
        eff_addr_upper_reg <= (word_access && mem_access_next) ?
          {eff_addr_next[15:1], 1'b1} : eff_addr_next;
        mem_access_reg <= mem_access_next;
        reg_access_reg <= reg_access_next;
        reg_slot_reg <= reg_slot_next;
        operand_data_reg <= operand_data_next;
        addr_fault_reg <= addr_fault_next;
      end
    end
  end

  // Register file; a multiply result beats a same-cycle external write
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      for (i = 0; i < `REG_COUNT; i = i + 1) begin
        gpr[i] <= `ZERO_BYTE;
      end
    end else if (clk_en) begin
      if (req_valid && product_next) begin
        gpr[slot_of(bank, `CODE_X)] <= ax_product[7:0];
        gpr[slot_of(bank, `CODE_A)] <= ax_product[15:8];
      end else if (wr_en) begin
        gpr[slot_of(bank, wr_byte_code)] <= wr_data;
      end
    end
  end

  assign done = done_reg;
  assign eff_addr = eff_addr_reg;
  assign eff_addr_upper = eff_addr_upper_reg;
  assign mem_access = mem_access_reg;
  assign reg_access = reg_access_reg;
  assign reg_slot = reg_slot_reg;
  assign operand_data = operand_data_reg;
  assign addr_fault = addr_fault_reg;
  assign product_written = product_written_reg;

endmodule // operand_address_generator

// ---- test/operand_address_generator_asserts.sv ----
`timescale 1ns/100ps
module operand_address_generator_asserts (
  input wire sys_clk,
  input wire reset_n,
  input wire clk_en,
  input wire req_valid,
  input wire [3:0] addr_mode,
  input wire [2:0] implied_op,
  input wire [2:0] byte_register_code,
  input wire bank_select_bit0,
  input wire bank_select_bit1,
  input wire [7:0] imm8,
  input wire [15:0] imm16,
  input wire [15:0] stack_pointer,
  input wire done,
  input wire [15:0] eff_addr,
  input wire mem_access,
  input wire reg_access,
  input wire [4:0] reg_slot,
  input wire addr_fault,
  input wire product_written
);
  wire take = reset_n & clk_en & req_valid;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_done_follows: assert property (take |=> done) else $error("done missing");
  a_direct_pass: assert property (
    take && addr_mode == 4'h3 |=> mem_access && eff_addr == $past(imm16))
    else $error("direct address");
  a_short_form: assert property (
    take && addr_mode == 4'h4 |=> mem_access
    && eff_addr == {7'h7F, $past(imm8) < 8'h20, $past(imm8)}) else $error("short address");
  a_special_form: assert property (
    take && addr_mode == 4'h5 && imm8[7:4] != 4'hD |=> eff_addr == {8'hFF, $past(imm8)})
    else $error("special address");
  a_special_hole: assert property (
    take && addr_mode == 4'h5 && imm8[7:4] == 4'hD |=> addr_fault && !mem_access)
    else $error("special hole");
  a_stack_window: assert property (
    take && addr_mode == 4'h9 |=> mem_access == ($past(stack_pointer) >= 16'hFB00
    && $past(stack_pointer) <= 16'hFEFF)) else $error("stack window");
  a_stack_addr: assert property (
    take && addr_mode == 4'h9 |=> !mem_access || eff_addr == $past(stack_pointer))
    else $error("stack address");
  a_fault_clean: assert property (
    addr_fault |-> !mem_access && !reg_access && eff_addr == 16'h0000)
    else $error("fault outputs");
  a_product_slot: assert property (
    take && addr_mode == 4'h0 && implied_op == 3'h0 |=> product_written
    && reg_slot[2:0] == 3'h1) else $error("product slot");
  a_byte_slot: assert property (
    take && addr_mode == 4'h1 |=> reg_access && reg_slot == {$past(bank_select_bit1),
    $past(bank_select_bit0), $past(byte_register_code)}) else $error("byte slot");
endmodule // operand_address_generator_asserts
bind operand_address_generator operand_address_generator_asserts chk_i (.*);

// ---- test/memory_bus_model.sv ----
`timescale 1ns/100ps
module memory_bus_model (
  input wire sys_clk,
  input wire done,
  input wire mem_access,
  input wire [15:0] eff_addr,
  output logic [15:0] last_addr
);
  initial last_addr = 16'h0000;
  // A bus cycle only starts from a finished memory request
  always @(posedge sys_clk) begin
    if (done && mem_access) last_addr <= eff_addr;
  end
endmodule // memory_bus_model

// ---- test/testbench.sv ----
`timescale 1ns/100ps
module testbench;
  reg sys_clk = 0, reset_n = 0, clk_en = 1, req_valid = 0, index_use_c = 0;
  reg bank_select_bit0 = 0, bank_select_bit1 = 0, word_access = 0, wr_en = 0;
  reg [3:0] addr_mode = 4'h0;
  reg [2:0] implied_op = 3'h0, byte_register_code = 3'h0, wr_byte_code = 3'h0;
  reg [1:0] pair_register_code = 2'h0;
  reg [7:0] imm8 = 8'h00, wr_data = 8'h00;
  reg [15:0] imm16 = 16'h0000, stack_pointer = 16'h0000;
  wire done, mem_access, reg_access, addr_fault, product_written;
  wire [15:0] eff_addr, eff_addr_upper, operand_data, last_addr;
  wire [4:0] reg_slot;
  int err_total = 0;
  int samples_checked = 0;
  operand_address_generator dut (.*);
  memory_bus_model mem (.*);
  initial forever #5 sys_clk = ~sys_clk;
  task automatic chk(input string what, input [15:0] exp, input [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic [7:0] bv(input [1:0] b, input [2:0] c);
    bv = {3'h5, b, c};
  endfunction
  task automatic wr(input [2:0] c, input [7:0] d);
    @(negedge sys_clk);
    {wr_en, wr_byte_code, wr_data} = {1'b1, c, d};
    @(negedge sys_clk);
    wr_en = 1'b0;
  endtask
  task automatic go(input [3:0] m);
    @(negedge sys_clk);
    {addr_mode, req_valid} = {m, 1'b1};
    @(negedge sys_clk);
    req_valid = 1'b0;
    chk("done", 16'h0001, {15'h0, done});
  endtask
  task automatic t_regs;
    for (int b = 0; b < 4; b++) begin
      {bank_select_bit1, bank_select_bit0} = b[1:0];
      for (int c = 0; c < 8; c++) wr(c[2:0], bv(b[1:0], c[2:0]));
    end
    // All banks filled first, so a bank mix-up shows on read
    for (int b = 0; b < 4; b++) begin
      {bank_select_bit1, bank_select_bit0} = b[1:0];
      for (int c = 0; c < 8; c++) begin
        byte_register_code = c[2:0];
        go(4'h1);
        chk("byte", {8'h0, bv(b[1:0], c[2:0])}, operand_data);
        chk("slot", {11'h0, b[1:0], c[2:0]}, {11'h0, reg_slot});
      end
      for (int p = 0; p < 4; p++) begin
        pair_register_code = p[1:0];
        go(4'h2);
        chk("pair", {bv(b[1:0], {p[1:0], 1'b1}), bv(b[1:0], {p[1:0], 1'b0})}, operand_data);
      end
    end
  endtask
  task automatic t_implied;
    {bank_select_bit1, bank_select_bit0} = 2'h0;
    wr(3'h1, 8'h12);
    wr(3'h0, 8'h34);
    implied_op = 3'h0;
    go(4'h0);
    chk("product", 16'h03A8, operand_data);
    chk("written", 16'h0001, {15'h0, product_written});
    for (int op = 2; op < 6; op++) begin
      implied_op = op[2:0];
      go(4'h0);
      chk("acc", 16'h0021, {10'h0, reg_access, reg_slot});
      chk("once", 16'h0000, {15'h0, product_written});
    end
    implied_op = 3'h1;
    go(4'h0);
    chk("x low", 16'h00A8, operand_data);
    chk("x slot", 16'h0020, {10'h0, reg_access, reg_slot});
    pair_register_code = 2'h0;
    go(4'h2);
    chk("ax", 16'h03A8, operand_data);
    implied_op = 3'h6;
    go(4'h0);
    chk("bad op", 16'h0001, {15'h0, addr_fault});
  endtask
  task automatic t_direct;
    {imm16, word_access} = {16'hFE00, 1'b1};
    go(4'h3);
    chk("direct", 16'hFE00, eff_addr);
    chk("upper", 16'hFE01, eff_addr_upper);
    chk("mem", 16'h0001, {15'h0, mem_access});
    word_access = 1'b0;
    @(negedge sys_clk);
    chk("bus", 16'hFE00, last_addr);
    {imm8, word_access} = {8'h30, 1'b1};
    go(4'h4);
    chk("short word", 16'hFE31, eff_addr_upper);
    imm8 = 8'hE0;
    go(4'h5);
    chk("sfr word", 16'hFFE1, eff_addr_upper);
    word_access = 1'b0;
  endtask
  task automatic t_short_special;
    logic [7:0] si[10] = '{8'h00, 8'h1F, 8'h20, 8'hFF, 8'h20, 8'hCF, 8'hE0, 8'hFF, 8'hD0, 8'hDF};
    logic [15:0] se[10] = '{16'hFF00, 16'hFF1F, 16'hFE20, 16'hFEFF, 16'hFF20, 16'hFFCF,
      16'hFFE0, 16'hFFFF, 16'h0000, 16'h0000};
    for (int i = 0; i < 10; i++) begin
      imm8 = si[i];
      go(i < 4 ? 4'h4 : 4'h5);
      chk("saddr", se[i], eff_addr);
      chk("supper", se[i], eff_addr_upper);
      chk("fault", {15'h0, i > 7}, {15'h0, addr_fault});
    end
  endtask
  task automatic t_pointer;
    {bank_select_bit1, bank_select_bit0} = 2'h2;
    wr(3'h4, 8'h34);
    wr(3'h5, 8'h12);
    wr(3'h6, 8'hFF);
    wr(3'h7, 8'hFF);
    pair_register_code = 2'h2;
    go(4'h6);
    chk("de", 16'h1234, eff_addr);
    pair_register_code = 2'h3;
    go(4'h6);
    chk("hl", 16'hFFFF, eff_addr);
    pair_register_code = 2'h1;
    go(4'h6);
    chk("bc fault", 16'h0001, {15'h0, addr_fault});
    imm8 = 8'h02;
    go(4'h7);
    chk("based", 16'h0001, eff_addr);
    for (int c = 0; c < 2; c++) begin
      index_use_c = c[0];
      go(4'h8);
      chk("indexed", c ? 16'h00B1 : 16'h00B2, eff_addr);
    end
  endtask
  task automatic t_stack;
    logic [15:0] sp[4] = '{16'hFB00, 16'hFEFF, 16'hFAFF, 16'hFF00};
    for (int i = 0; i < 4; i++) begin
      stack_pointer = sp[i];
      go(4'h9);
      chk("stack", i < 2 ? sp[i] : 16'h0000, eff_addr);
      chk("sfault", {15'h0, i > 1}, {15'h0, addr_fault});
    end
  endtask
  task automatic t_hold;
    {bank_select_bit1, bank_select_bit0} = 2'h0;
    imm16 = 16'h1234;
    go(4'h3);
    @(negedge sys_clk);
    {clk_en, req_valid, imm16} = {1'b0, 1'b1, 16'h5678};
    @(negedge sys_clk);
    chk("frozen", 16'h1234, eff_addr);
    chk("no done", 16'h0000, {15'h0, done});
    {clk_en, req_valid, reset_n} = 3'h4;
    @(negedge sys_clk);
    reset_n = 1'b1;
    chk("reset", 16'h0000, eff_addr);
    byte_register_code = 3'h1;
    go(4'h1);
    chk("cleared", 16'h0000, operand_data);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge sys_clk);
    reset_n = 1'b1;
    t_regs;
    t_implied;
    t_direct;
    t_short_special;
    t_pointer;
    t_stack;
    t_hold;
    test_done;
  end
endmodule // testbench
